//--- src/dcg_defs.vh
/*
  Constants for the deep-sleep clock gate bank: register offsets, field
  positions, reset values and write masks.
  Assumes it is included by bare name from the design files of the bank.
*/
`ifndef DCG_DEFS_VH
`define DCG_DEFS_VH

// APB address width and register byte offsets
`define DCG_ADDR_W          12
`define DCG_OFF_RUN_CFG     12'h060
`define DCG_OFF_RUN_GATE    12'h104
`define DCG_OFF_SLEEP_GATE  12'h114
`define DCG_OFF_DEEP_GATE   12'h124
`define DCG_OFF_GATE_STAT   12'h128
`define DCG_OFF_FAULT_STAT  12'h12c

// Gate register layout: reset value and implemented bits
`define DCG_GATE_RESET      32'h0000_0000
`define DCG_GATE_WMASK      32'h0707_1011
`define DCG_BIT_CMP2        26
`define DCG_BIT_CMP1        25
`define DCG_BIT_CMP0        24
`define DCG_BIT_GPC2        18
`define DCG_BIT_GPC1        17
`define DCG_BIT_GPC0        16
`define DCG_BIT_TWI         12
`define DCG_BIT_SSP         4
`define DCG_BIT_ASP         0

// Run clock configuration register
`define DCG_CFG_RESET       32'h0000_0000
`define DCG_CFG_WMASK       32'h0800_0000
`define DCG_CFG_ACG_BIT     27

// Gate status register: mode field position
`define DCG_STAT_MODE_LSB   28

// Fault status register fields
`define DCG_FLT_FLAG_BIT    31
`define DCG_FLT_CNT_LSB     8
`define DCG_FLT_UNIT_LSB    0

// Number of gated units and unit index width
`define DCG_UNITS           9
`define DCG_SEL_W           4

`endif

//--- src/dcg_gate_reg.v
/*
  One 32-bit clock gating register with fixed reserved bits.
  Assumes a synchronous active-high reset and a one-cycle write strobe
  from the bus slave on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dcg_defs.vh"

module dcg_gate_reg (
  input  wire        clk,
  input  wire        rst,
  input  wire        wr_en,
  input  wire [31:0] wdata,
  output reg  [31:0] q
);

  // Reset clears every enable, reserved bits never store
  always @(posedge clk) begin
    if (rst) begin
      q <= `DCG_GATE_RESET;
    end else if (wr_en) begin
      q <= wdata & `DCG_GATE_WMASK;
    end
  end

endmodule
`default_nettype wire

//--- src/dcg_fault_check.v
/*
  Checks peripheral accesses against the applied clock gates and answers
  each with a one-cycle done pulse, flagged as a bus fault when the unit
  is unclocked or the unit index does not exist.
  Assumes request and index come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dcg_defs.vh"

module dcg_fault_check (
  input  wire                  clk,
  input  wire                  rst,
  input  wire                  acc_req,
  input  wire [`DCG_SEL_W-1:0] acc_sel,
  input  wire [`DCG_UNITS-1:0] gate,
  output reg                   done_q,
  output reg                   fault_q
);

  wire unit_ok;

  // Unit exists and its clock is on
  assign unit_ok = (acc_sel < `DCG_UNITS) && gate[acc_sel];

  // One answer per request, fault for unclocked units
  always @(posedge clk) begin
    if (rst) begin
      done_q  <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      done_q  <= acc_req;
      fault_q <= acc_req & ~unit_ok;
    end
  end

endmodule
`default_nettype wire

//--- src/dcg_bank.v
/*
  Clock gate bank: run, sleep and deep-sleep gating registers, the run
  clock configuration with its automatic gating bit, a power mode
  tracker, the per-unit gate outputs and the bus fault check, all behind
  an APB slave with one wait state.
  Assumes the power controller and the peripheral bus decoder run on CLK,
  so their requests need no synchroniser.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dcg_defs.vh"

module dcg_bank (
  input  wire                  CLK,
  input  wire                  RST,
  input  wire                  PSEL,
  input  wire                  PENABLE,
  input  wire                  PWRITE,
  input  wire [`DCG_ADDR_W-1:0] PADDR,
  input  wire [31:0]           PWDATA,
  output reg  [31:0]           PRDATA,
  output reg                   PREADY,
  output reg                   PSLVERR,
  input  wire                  SLEEP_REQ,
  input  wire                  DEEP_SLEEP_REQ,
  input  wire                  UNIT_ACC_REQ,
  input  wire [`DCG_SEL_W-1:0] UNIT_ACC_SEL,
  output wire                  UNIT_ACC_DONE,
  output wire                  UNIT_ACC_FAULT,
  output reg  [1:0]            POWER_MODE,
  output reg                   COMPARATOR_TWO_GATE,
  output reg                   COMPARATOR_ONE_GATE,
  output reg                   COMPARATOR_ZERO_GATE,
  output reg                   GP_COUNTER_TWO_GATE,
  output reg                   GP_COUNTER_ONE_GATE,
  output reg                   GP_COUNTER_ZERO_GATE,
  output reg                   TWO_WIRE_PORT_GATE,
  output reg                   SYNC_SERIAL_PORT_GATE,
  output reg                   ASYNC_SERIAL_PORT_GATE
);

  // Power modes
  localparam [1:0] MODE_RUN   = 2'b00;
  localparam [1:0] MODE_SLEEP = 2'b01;
  localparam [1:0] MODE_DEEP  = 2'b10;

  // Pack the nine implemented enables into unit order
  function [`DCG_UNITS-1:0] pack_gate;
    input [31:0] r;
    begin
      pack_gate = {r[`DCG_BIT_CMP2], r[`DCG_BIT_CMP1],
                   r[`DCG_BIT_CMP0], r[`DCG_BIT_GPC2],
                   r[`DCG_BIT_GPC1], r[`DCG_BIT_GPC0],
                   r[`DCG_BIT_TWI],
                   r[`DCG_BIT_SSP],
                   r[`DCG_BIT_ASP]};
    end
  endfunction

  // Spread the nine unit enables back into register layout
  function [31:0] unpack_gate;
    input [`DCG_UNITS-1:0] g;
    begin
      unpack_gate                 = 32'h0000_0000;
      unpack_gate[`DCG_BIT_CMP2]  = g[8];
      unpack_gate[`DCG_BIT_CMP1]  = g[7];
      unpack_gate[`DCG_BIT_CMP0]  = g[6];
      unpack_gate[`DCG_BIT_GPC2]  = g[5];
      unpack_gate[`DCG_BIT_GPC1]  = g[4];
      unpack_gate[`DCG_BIT_GPC0]  = g[3];
      unpack_gate[`DCG_BIT_TWI]   = g[2];
      unpack_gate[`DCG_BIT_SSP]   = g[1];
      unpack_gate[`DCG_BIT_ASP]   = g[0];
    end
  endfunction

  // Bus state
  reg                   ready_q;
  reg                   slverr_q;
  reg  [31:0]           rdata_q;
  reg                   ready_d;
  reg                   slverr_d;
  reg  [31:0]           rdata_d;

  // Configuration and status state
  reg  [31:0]           run_cfg_q;
  reg  [1:0]            mode_q;
  reg  [1:0]            mode_d;
  reg  [`DCG_UNITS-1:0] gate_q;
  reg  [`DCG_UNITS-1:0] gate_d;
  reg                   flt_flag_q;
  reg  [7:0]            flt_cnt_q;
  reg  [`DCG_SEL_W-1:0] flt_unit_q;
  reg  [`DCG_SEL_W-1:0] acc_sel_q;

  // Decode and strobes
  reg                   hit_run_cfg;
  reg                   hit_run_gate;
  reg                   hit_sleep_gate;
  reg                   hit_deep_gate;
  reg                   hit_gate_stat;
  reg                   hit_flt_stat;
  wire                  addr_hit;
  wire                  acc_phase;
  wire                  xfer_done;
  wire                  wr_ok;
  wire                  flt_clear;
  wire                  auto_clock_gating;
  wire [31:0]           run_gate_reg;
  wire [31:0]           sleep_gate_reg;
  wire [31:0]           deep_gate_reg;
  wire                  chk_done;
  wire                  chk_fault;

  // Address decode of the six mapped words
  always @* begin
    hit_run_cfg    = 1'b0;
    hit_run_gate   = 1'b0;
    hit_sleep_gate = 1'b0;
    hit_deep_gate  = 1'b0;
    hit_gate_stat  = 1'b0;
    hit_flt_stat   = 1'b0;
    if (PADDR == `DCG_OFF_RUN_CFG) begin
      hit_run_cfg = 1'b1;
    end else if (PADDR == `DCG_OFF_RUN_GATE) begin
      hit_run_gate = 1'b1;
    end else if (PADDR == `DCG_OFF_SLEEP_GATE) begin
      hit_sleep_gate = 1'b1;
    end else if (PADDR == `DCG_OFF_DEEP_GATE) begin
      hit_deep_gate = 1'b1;
    end else if (PADDR == `DCG_OFF_GATE_STAT) begin
      hit_gate_stat = 1'b1;
    end else if (PADDR == `DCG_OFF_FAULT_STAT) begin
      hit_flt_stat = 1'b1;
    end
  end

  assign addr_hit  = hit_run_cfg | hit_run_gate | hit_sleep_gate |
                     hit_deep_gate | hit_gate_stat | hit_flt_stat;
  // Access phase and the edge at which the master samples ready
  assign acc_phase = PSEL & PENABLE;
  assign xfer_done = acc_phase & ready_q;
  // Writes land only at the completing edge and only without error
  assign wr_ok     = xfer_done & PWRITE & ~slverr_q;
  assign flt_clear = wr_ok & hit_flt_stat & PWDATA[`DCG_FLT_FLAG_BIT];
  assign auto_clock_gating       = run_cfg_q[`DCG_CFG_ACG_BIT];

  // Ready and error one cycle into the access phase
  always @* begin
    ready_d  = acc_phase & ~ready_q;
    slverr_d = acc_phase & ~ready_q & ~addr_hit;
  end

  // Read data assembled for the answering cycle
  always @* begin
    rdata_d = 32'h0000_0000;
    if (acc_phase & ~ready_q & ~PWRITE) begin
      if (hit_run_cfg) begin
        rdata_d = run_cfg_q;
      end else if (hit_run_gate) begin
        rdata_d = run_gate_reg;
      end else if (hit_sleep_gate) begin
        rdata_d = sleep_gate_reg;
      end else if (hit_deep_gate) begin
        rdata_d = deep_gate_reg;
      end else if (hit_gate_stat) begin
        rdata_d = unpack_gate(gate_q);
        rdata_d[`DCG_STAT_MODE_LSB+1:`DCG_STAT_MODE_LSB] = mode_q;
      end else if (hit_flt_stat) begin
        rdata_d[`DCG_FLT_FLAG_BIT] = flt_flag_q;
        rdata_d[`DCG_FLT_CNT_LSB+7:`DCG_FLT_CNT_LSB] = flt_cnt_q;
        rdata_d[`DCG_FLT_UNIT_LSB+`DCG_SEL_W-1:`DCG_FLT_UNIT_LSB] =
          flt_unit_q;
      end
    end
  end

  // APB answer registers
  always @(posedge CLK) begin
    if (RST) begin
      ready_q  <= 1'b0;
      slverr_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end else begin
      ready_q  <= ready_d;
      slverr_q <= slverr_d;
      rdata_q  <= rdata_d;
    end
  end

  // Bus outputs straight from flip-flops
  always @* begin
    PREADY  = ready_q;
    PSLVERR = slverr_q;
    PRDATA  = rdata_q;
  end

  // Run clock configuration, only the auto gating bit stores
  always @(posedge CLK) begin
    if (RST) begin
      run_cfg_q <= `DCG_CFG_RESET;
    end else if (wr_ok & hit_run_cfg) begin
      run_cfg_q <= PWDATA & `DCG_CFG_WMASK;
    end
  end

  // Three gating registers of one layout
  dcg_gate_reg u_run_gate (
    .clk   (CLK),
    .rst   (RST),
    .wr_en (wr_ok & hit_run_gate),
    .wdata (PWDATA),
    .q     (run_gate_reg)
  );

  dcg_gate_reg u_sleep_gate (
    .clk   (CLK),
    .rst   (RST),
    .wr_en (wr_ok & hit_sleep_gate),
    .wdata (PWDATA),
    .q     (sleep_gate_reg)
  );

  dcg_gate_reg u_deep_gate (
    .clk   (CLK),
    .rst   (RST),
    .wr_en (wr_ok & hit_deep_gate),
    .wdata (PWDATA),
    .q     (deep_gate_reg)
  );

  // Power mode tracker, deep sleep outranks sleep
  always @* begin
    mode_d = mode_q;
    case (mode_q)
      MODE_RUN: begin
        if (DEEP_SLEEP_REQ) begin
          mode_d = MODE_DEEP;
        end else if (SLEEP_REQ) begin
          mode_d = MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        if (DEEP_SLEEP_REQ) begin
          mode_d = MODE_DEEP;
        end else if (!SLEEP_REQ) begin
          mode_d = MODE_RUN;
        end
      end
      MODE_DEEP: begin
        if (!DEEP_SLEEP_REQ) begin
          mode_d = SLEEP_REQ ? MODE_SLEEP : MODE_RUN;
        end
      end
      default: begin
        mode_d = MODE_RUN;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      mode_q <= MODE_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Pick the register of the current mode for the applied gates
  always @* begin
    gate_d = pack_gate(run_gate_reg);
    if (auto_clock_gating && (mode_q == MODE_DEEP)) begin
      gate_d = pack_gate(deep_gate_reg);
    end else if (auto_clock_gating && (mode_q == MODE_SLEEP)) begin
      gate_d = pack_gate(sleep_gate_reg);
    end
  end

  always @(posedge CLK) begin
    if (RST) begin
      gate_q <= {`DCG_UNITS{1'b0}};
    end else begin
      gate_q <= gate_d;
    end
  end

  // Gate outputs, one per unit, enabled only by software
  always @* begin
    COMPARATOR_TWO_GATE    = gate_q[8];
    COMPARATOR_ONE_GATE    = gate_q[7];
    COMPARATOR_ZERO_GATE   = gate_q[6];
    GP_COUNTER_TWO_GATE    = gate_q[5];
    GP_COUNTER_ONE_GATE    = gate_q[4];
    GP_COUNTER_ZERO_GATE   = gate_q[3];
    TWO_WIRE_PORT_GATE     = gate_q[2];
    SYNC_SERIAL_PORT_GATE  = gate_q[1];
    ASYNC_SERIAL_PORT_GATE = gate_q[0];
    POWER_MODE             = mode_q;
  end

  // Bus fault check against the applied gates
  dcg_fault_check u_fault_check (
    .clk     (CLK),
    .rst     (RST),
    .acc_req (UNIT_ACC_REQ),
    .acc_sel (UNIT_ACC_SEL),
    .gate    (gate_q),
    .done_q  (chk_done),
    .fault_q (chk_fault)
  );

  assign UNIT_ACC_DONE  = chk_done;
  assign UNIT_ACC_FAULT = chk_fault;

  // Unit index held for the fault record
  always @(posedge CLK) begin
    if (RST) begin
      acc_sel_q <= {`DCG_SEL_W{1'b0}};
    end else if (UNIT_ACC_REQ) begin
      acc_sel_q <= UNIT_ACC_SEL;
    end
  end

  // Sticky fault record, a new fault wins over a clear
  always @(posedge CLK) begin
    if (RST) begin
      flt_flag_q <= 1'b0;
      flt_cnt_q  <= 8'h00;
      flt_unit_q <= {`DCG_SEL_W{1'b0}};
    end else if (chk_fault) begin
      flt_flag_q <= 1'b1;
      flt_unit_q <= acc_sel_q;
      if (flt_clear) begin
        flt_cnt_q <= 8'h01;
      end else if (flt_cnt_q != 8'hff) begin
        flt_cnt_q <= flt_cnt_q + 8'h01;
      end
    end else if (flt_clear) begin
      flt_flag_q <= 1'b0;
      flt_cnt_q  <= 8'h00;
    end
  end

endmodule
`default_nettype wire

//--- testbench/dcg_bank_props.sv
/*
  Port checker for the clock gate bank: APB answer timing, unit access
  answers, power mode tracking and gate output behaviour.
  Assumes it is bound to dcg_bank, one clock CLK, reset RST sync high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dcg_defs.vh"

module dcg_bank_props (
  input wire logic                  CLK,
  input wire logic                  RST,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PREADY,
  input wire logic                  PSLVERR,
  input wire logic [31:0]           PRDATA,
  input wire logic                  SLEEP_REQ,
  input wire logic                  DEEP_SLEEP_REQ,
  input wire logic                  UNIT_ACC_REQ,
  input wire logic [`DCG_SEL_W-1:0] UNIT_ACC_SEL,
  input wire logic                  UNIT_ACC_DONE,
  input wire logic                  UNIT_ACC_FAULT,
  input wire logic [1:0]            POWER_MODE,
  input wire logic                  COMPARATOR_TWO_GATE,
  input wire logic                  COMPARATOR_ONE_GATE,
  input wire logic                  COMPARATOR_ZERO_GATE,
  input wire logic                  GP_COUNTER_TWO_GATE,
  input wire logic                  GP_COUNTER_ONE_GATE,
  input wire logic                  GP_COUNTER_ZERO_GATE,
  input wire logic                  TWO_WIRE_PORT_GATE,
  input wire logic                  SYNC_SERIAL_PORT_GATE,
  input wire logic                  ASYNC_SERIAL_PORT_GATE
);
  wire [8:0] gv;
  wire       sel_gate;

  // Gates in unit index order, and the gate of the addressed unit
  assign gv = {COMPARATOR_TWO_GATE, COMPARATOR_ONE_GATE,
    COMPARATOR_ZERO_GATE, GP_COUNTER_TWO_GATE, GP_COUNTER_ONE_GATE,
    GP_COUNTER_ZERO_GATE, TWO_WIRE_PORT_GATE, SYNC_SERIAL_PORT_GATE,
    ASYNC_SERIAL_PORT_GATE};
  assign sel_gate = gv[UNIT_ACC_SEL];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Reset clears every gate and the mode
  reset_zero_a: assert property (disable iff (1'b0)
    RST |=> gv == 9'h0 && POWER_MODE == 2'b00)
    else $error("gates not cleared by reset");
  unit_answer_a: assert property (UNIT_ACC_REQ |=> UNIT_ACC_DONE)
    else $error("unit access not answered");
  no_unit_a: assert property (
    UNIT_ACC_REQ && UNIT_ACC_SEL > 8 |=> UNIT_ACC_FAULT)
    else $error("missing unit not faulted");
  gated_fault_a: assert property (
    UNIT_ACC_REQ && UNIT_ACC_SEL < 9 |=> UNIT_ACC_FAULT != $past(sel_gate))
    else $error("fault does not match gate");
  fault_done_a: assert property (UNIT_ACC_FAULT |-> UNIT_ACC_DONE)
    else $error("fault without done");
  deep_mode_a: assert property (
    !$past(RST) && $past(DEEP_SLEEP_REQ) |-> POWER_MODE == 2'b10)
    else $error("deep mode not entered");
  sleep_mode_a: assert property (
    !DEEP_SLEEP_REQ && SLEEP_REQ |=> POWER_MODE == 2'b01)
    else $error("sleep mode not entered");
  // Gates move only after a bus write or a mode change
  gate_hold_a: assert property (
    (!PSEL && $stable(POWER_MODE)) [*3] |=> $stable(gv))
    else $error("gate changed without cause");
  ready_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no ready after one wait state");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("slave error without ready");
  rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");

  // Main scenarios reached
  cover property (POWER_MODE == 2'b10 && gv != 9'h0);
  cover property (PSLVERR);
  cover property (UNIT_ACC_FAULT);
endmodule

bind dcg_bank dcg_bank_props chk_u (.CLK(CLK), .RST(RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
  .SLEEP_REQ(SLEEP_REQ), .DEEP_SLEEP_REQ(DEEP_SLEEP_REQ),
  .UNIT_ACC_REQ(UNIT_ACC_REQ), .UNIT_ACC_SEL(UNIT_ACC_SEL),
  .UNIT_ACC_DONE(UNIT_ACC_DONE), .UNIT_ACC_FAULT(UNIT_ACC_FAULT),
  .POWER_MODE(POWER_MODE), .COMPARATOR_TWO_GATE(COMPARATOR_TWO_GATE),
  .COMPARATOR_ONE_GATE(COMPARATOR_ONE_GATE),
  .COMPARATOR_ZERO_GATE(COMPARATOR_ZERO_GATE),
  .GP_COUNTER_TWO_GATE(GP_COUNTER_TWO_GATE),
  .GP_COUNTER_ONE_GATE(GP_COUNTER_ONE_GATE),
  .GP_COUNTER_ZERO_GATE(GP_COUNTER_ZERO_GATE),
  .TWO_WIRE_PORT_GATE(TWO_WIRE_PORT_GATE),
  .SYNC_SERIAL_PORT_GATE(SYNC_SERIAL_PORT_GATE),
  .ASYNC_SERIAL_PORT_GATE(ASYNC_SERIAL_PORT_GATE));

`default_nettype wire

//--- testbench/dcg_bank_tb.sv
/*
  Self-checking bench for the clock gate bank: APB register traffic,
  power mode requests and unit accesses with expected answers.
  Assumes dcg_bank and dcg_defs.vh from src, clock at 20 MHz.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dcg_defs.vh"

module dcg_bank_tb;
  logic        CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
  logic        SLEEP_REQ, DEEP_SLEEP_REQ, UNIT_ACC_REQ;
  logic        UNIT_ACC_DONE, UNIT_ACC_FAULT;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd_v;
  logic [3:0]  UNIT_ACC_SEL;
  logic [1:0]  POWER_MODE;
  wire  [8:0]  gv;
  int          fails, checks_done;
  int          pos [9] = '{0, 4, 12, 16, 17, 18, 24, 25, 26};

  dcg_bank dut_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_REQ(SLEEP_REQ),
    .DEEP_SLEEP_REQ(DEEP_SLEEP_REQ), .UNIT_ACC_REQ(UNIT_ACC_REQ),
    .UNIT_ACC_SEL(UNIT_ACC_SEL), .UNIT_ACC_DONE(UNIT_ACC_DONE),
    .UNIT_ACC_FAULT(UNIT_ACC_FAULT), .POWER_MODE(POWER_MODE),
    .COMPARATOR_TWO_GATE(gv[8]), .COMPARATOR_ONE_GATE(gv[7]),
    .COMPARATOR_ZERO_GATE(gv[6]), .GP_COUNTER_TWO_GATE(gv[5]),
    .GP_COUNTER_ONE_GATE(gv[4]), .GP_COUNTER_ZERO_GATE(gv[3]),
    .TWO_WIRE_PORT_GATE(gv[2]), .SYNC_SERIAL_PORT_GATE(gv[1]),
    .ASYNC_SERIAL_PORT_GATE(gv[0]));

  // Compare and report
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer, waits for ready, checks the error answer
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic ee);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd_v = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    chk("slave error", {31'h0, ee}, {31'h0, err});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk("read data", e, rd_v);
  endtask

  // One unit access pulse, answer sampled in the cycle after it
  task automatic acc(input logic [3:0] s, input logic f);
    @(posedge CLK);
    UNIT_ACC_REQ <= 1'b1;
    UNIT_ACC_SEL <= s;
    @(posedge CLK);
    UNIT_ACC_REQ <= 1'b0;
    @(posedge CLK);
    chk("unit done", 32'h1, {31'h0, UNIT_ACC_DONE});
    chk("unit fault", {31'h0, f}, {31'h0, UNIT_ACC_FAULT});
  endtask

  // Let gates settle, then compare them
  task automatic gchk(input logic [8:0] e);
    repeat (3) @(posedge CLK);
    chk("gates", {23'h0, e}, {23'h0, gv});
  endtask

  task automatic finish_test;
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Clock
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  // Hang guard, far beyond the few hundred cycles of the tests
  initial begin
    #200000;
    fails++;
    finish_test;
  end

  // Test sequence
  initial begin
    {PSEL, PENABLE, PWRITE, SLEEP_REQ, DEEP_SLEEP_REQ, UNIT_ACC_REQ} = '0;
    {PADDR, PWDATA, UNIT_ACC_SEL} = '0;
    RST = 1'b1;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    rd(`DCG_OFF_DEEP_GATE, 32'h0);
    rd(`DCG_OFF_RUN_GATE, 32'h0);
    rd(`DCG_OFF_SLEEP_GATE, 32'h0);
    gchk(9'h0);
    wr(`DCG_OFF_DEEP_GATE, 32'hffff_ffff);
    rd(`DCG_OFF_DEEP_GATE, 32'h0707_1011);
    apb(1'b1, 12'h200, 32'h1, 1'b1);
    for (int i = 0; i < 10; i++) acc(i[3:0], 1'b1);
    DEEP_SLEEP_REQ <= 1'b1;
    gchk(9'h0);
    wr(`DCG_OFF_RUN_CFG, 32'h0800_0000);
    gchk(9'h1ff);
    chk("mode", 32'h2, {30'h0, POWER_MODE});
    // Walk one enable bit through every unit
    for (int i = 0; i < 9; i++) begin
      wr(`DCG_OFF_DEEP_GATE, 32'h1 << pos[i]);
      gchk(9'h1 << i);
      acc(i[3:0], 1'b0);
      acc(4'((i + 1) % 9), 1'b1);
    end
    // Status words: deep mode with comparator two, then 19 faults, last unit 0
    rd(`DCG_OFF_GATE_STAT, 32'h2400_0000);
    rd(`DCG_OFF_FAULT_STAT, 32'h8000_1300);
    wr(`DCG_OFF_FAULT_STAT, 32'h8000_0000);
    rd(`DCG_OFF_FAULT_STAT, 32'h0);
    wr(`DCG_OFF_SLEEP_GATE, 32'h10);
    DEEP_SLEEP_REQ <= 1'b0;
    SLEEP_REQ <= 1'b1;
    gchk(9'h002);
    wr(`DCG_OFF_RUN_GATE, 32'h0100_0000);
    gchk(9'h002);
    SLEEP_REQ <= 1'b0;
    gchk(9'h040);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    gchk(9'h0);
    rd(`DCG_OFF_DEEP_GATE, 32'h0);
    finish_test;
  end
endmodule

`default_nettype wire
